/* File: hw/pfsw_defines.svh */
// Register offsets, field positions, unlock keys, erased word and timing counts for the flash sequencer
`ifndef PFSW_DEFINES_SVH
`define PFSW_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFSW_ADDR_LOW_OFS 12'h000
`define PFSW_ADDR_HIGH_OFS 12'h004
`define PFSW_DATA_LOW_OFS 12'h008
`define PFSW_DATA_HIGH_OFS 12'h00c
`define PFSW_CON1_OFS 12'h010
`define PFSW_UNLOCK_OFS 12'h014

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PFSW_BIT_READ 0
`define PFSW_BIT_WRITE 1
`define PFSW_BIT_ENABLE 2
`define PFSW_BIT_ERROR 3
`define PFSW_BIT_ERASE 4
`define PFSW_BIT_LATCH 5
`define PFSW_BIT_CFGSEL 6

// ----------------------------------------
// Unlock keys and timing
// ----------------------------------------
`define PFSW_KEY_FIRST 8'h55
`define PFSW_KEY_SECOND 8'haa
`define PFSW_WRITE_TIME_US 2
`define PFSW_CLK_MHZ 200
`define PFSW_WRITE_CYCLES (`PFSW_WRITE_TIME_US * `PFSW_CLK_MHZ)
`define PFSW_ERASED_WORD 14'h3fff

`endif

/* File: hw/pfsw_pkg.sv */
// Types shared by the flash sequencer
package pfsw_pkg;
  typedef enum logic [1:0] {
    PFSW_IDLE,
    PFSW_ERASE,
    PFSW_PROGRAM
  } pfsw_state_t;
  typedef enum logic [1:0] {
    PFSW_KEY_NONE,
    PFSW_KEY_HALF,
    PFSW_KEY_OPEN
  } pfsw_key_t;
endpackage

/* File: hw/pfsw_top.sv */
// Program flash self-write sequencer with APB register access and a modelled array
//
// Operation
// - Erase leaves bits at one; programming only pulls ones to zero.
// - Array is rows of 32 fourteen-bit words; row is smallest erase.
// - Write latches are hidden and filled only through data register writes.
// - Every read returns exactly one flash word.
// - Program and erase duration comes from an internal timer.
// - Code protect blocks external programmer access, not self-write.
// - External bulk erase removes code protection, clearing everything; a reset also removes it while the protect bit is low.
// - Write-protect field blocks self-write over a part or all of array, except when config select is set.
// - Self-programming offers row erase and write only, no bulk erase.
// - Config select steers accesses to configuration area when set; here only reads go there, erase and program use the main array.
// - Latch-only write just loads a latch; erase ignores latch-only.
// - Error flag set on reset-interrupted, broken unlock or protected write.
// - Software zero to write bit ignored while operation runs.
// - Fetch and pointer ports read only; register interface writes too.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "pfsw_defines.svh"

module pfsw_top #(
  parameter int ADDR_W = 13,
  parameter int ROW_WORDS = 32,
  parameter int CFG_WORDS = 32,
  parameter int WRITE_CYCLES = `PFSW_WRITE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] write_protect_field,
  input wire logic code_protect_bit,
  input wire logic ext_prog_mode,
  input wire logic ext_bulk_erase,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic [13:0] fetch_data,
  input wire logic [ADDR_W-1:0] ptr_addr,
  output logic [13:0] ptr_data,
  input wire logic [ADDR_W-1:0] ext_addr,
  output logic [13:0] ext_rdata,
  output logic busy
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int ROW_W = $clog2(ROW_WORDS);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [13:0] flash_mem [DEPTH];
  logic [13:0] cfg_mem [CFG_WORDS];
  logic [13:0] latch_mem [ROW_WORDS];
  logic [ROW_WORDS-1:0] latch_used;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0] addr_low_reg;
  logic [7:0] addr_high_reg;
  logic [7:0] data_low_reg;
  logic [5:0] data_high_reg;
  logic cfgsel_reg;
  logic latch_reg;
  logic erase_reg;
  logic err_reg;
  logic enable_reg;
  logic write_reg;
  logic cp_reg;
  logic cp_strap_reg;
  logic [1:0] sync_a_reg;
  logic [1:0] sync_b_reg;
  pfsw_pkg::pfsw_key_t key_reg;
  pfsw_pkg::pfsw_state_t state_reg;
  logic [31:0] timer_reg;
  logic reset_seen_reg, live_reg;

  // Bus decode
  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  wire hit_alo = paddr == `PFSW_ADDR_LOW_OFS;
  wire hit_ahi = paddr == `PFSW_ADDR_HIGH_OFS;
  wire hit_dlo = paddr == `PFSW_DATA_LOW_OFS;
  wire hit_dhi = paddr == `PFSW_DATA_HIGH_OFS;
  wire hit_con = paddr == `PFSW_CON1_OFS;
  wire hit_unl = paddr == `PFSW_UNLOCK_OFS;
  wire mapped = hit_alo || hit_ahi || hit_dlo || hit_dhi || hit_con || hit_unl;
  wire [15:0] full_addr = {addr_high_reg, addr_low_reg};
  wire [ADDR_W-1:0] word_addr = full_addr[ADDR_W-1:0];
  wire [ROW_W-1:0] row_idx = word_addr[ROW_W-1:0];
  wire [4:0] cfg_idx = full_addr[4:0];
  wire idle = state_reg == pfsw_pkg::PFSW_IDLE;
  wire [13:0] wdata_word = {data_high_reg, data_low_reg};

  // Write-protect: 00 whole array, 01 lower half, 10 lower quarter, 11 none
  wire top_bit = word_addr[ADDR_W-1];
  wire top_two = |word_addr[ADDR_W-1 -: 2];
  wire prot_hit = (write_protect_field == 2'b00) ||
                  (write_protect_field == 2'b01 && !top_bit) ||
                  (write_protect_field == 2'b10 && !top_two);

  // Control register write decode
  wire con_wr = wr_acc && hit_con && idle;
  wire want_write = con_wr && pwdata[`PFSW_BIT_WRITE];
  wire key_ok = key_reg == pfsw_pkg::PFSW_KEY_OPEN;
  wire start_ok = want_write && key_ok && pwdata[`PFSW_BIT_ENABLE];
  wire start_prot = start_ok && prot_hit && !pwdata[`PFSW_BIT_CFGSEL];
  wire start_go = start_ok && !start_prot;
  // Broken unlock: write request without complete keys while enabled
  wire bad_unlock = want_write && pwdata[`PFSW_BIT_ENABLE] && !key_ok;
  wire eff_erase = con_wr ? pwdata[`PFSW_BIT_ERASE] : erase_reg;
  wire eff_latch = con_wr ? pwdata[`PFSW_BIT_LATCH] : latch_reg;
  wire eff_cfg = con_wr ? pwdata[`PFSW_BIT_CFGSEL] : cfgsel_reg;
  wire do_latch_only = start_go && !eff_erase && eff_latch;
  wire do_erase = start_go && eff_erase;
  wire do_program = start_go && !eff_erase && !eff_latch;
  wire do_read = con_wr && pwdata[`PFSW_BIT_READ];
  wire op_done = !idle && (timer_reg == 32'h0000_0001);
  wire err_set = start_prot || bad_unlock || (reset_seen_reg && live_reg);
  wire err_clr = con_wr && !pwdata[`PFSW_BIT_ERROR];

  // Read data mux, reserved bits zero
  wire [7:0] con_view = {1'b0, cfgsel_reg, latch_reg, erase_reg, err_reg,
                         enable_reg, write_reg, 1'b0};
  wire [7:0] rd_byte = hit_alo ? addr_low_reg :
                       hit_ahi ? addr_high_reg :
                       hit_dlo ? data_low_reg :
                       hit_dhi ? {2'b00, data_high_reg} :
                       hit_con ? con_view : 8'h00;

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign busy = !idle;

  // ----------------------------------------
  // Bus registers
  // ----------------------------------------
  // Address and data registers; read data is taken in setup and stands at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg <= 8'h00;
      addr_high_reg <= 8'h00;
      data_low_reg <= 8'h00;
      data_high_reg <= 6'h00;
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : prdata;
      if (wr_acc && hit_alo) addr_low_reg <= pwdata[7:0];
      if (wr_acc && hit_ahi) addr_high_reg <= pwdata[7:0];
      if (wr_acc && hit_dlo) data_low_reg <= pwdata[7:0];
      if (wr_acc && hit_dhi) data_high_reg <= pwdata[5:0];
      if (do_read && eff_cfg) begin
        // One word per read; select steers to config space
        {data_high_reg, data_low_reg} <= cfg_mem[cfg_idx];
      end else if (do_read) begin
        {data_high_reg, data_low_reg} <= flash_mem[word_addr];
      end
    end
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  // Write bit only set through unlock and enable; zero writes ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfgsel_reg <= 1'b0;
      latch_reg <= 1'b0;
      erase_reg <= 1'b0;
      enable_reg <= 1'b0;
      write_reg <= 1'b0;
    end else begin
      if (con_wr) begin
        cfgsel_reg <= pwdata[`PFSW_BIT_CFGSEL];
        latch_reg <= pwdata[`PFSW_BIT_LATCH];
        enable_reg <= pwdata[`PFSW_BIT_ENABLE];
      end
      if (con_wr) erase_reg <= pwdata[`PFSW_BIT_ERASE];
      else if (op_done && state_reg == pfsw_pkg::PFSW_ERASE) erase_reg <= 1'b0;
      if (do_erase || do_program) write_reg <= 1'b1;
      else if (op_done) write_reg <= 1'b0;
    end
  end

  // Error flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (err_set) begin
      err_reg <= 1'b1;
    end else if (err_clr) begin
      err_reg <= 1'b0;
    end
  end

  // Reset landing mid-operation is noted once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_seen_reg <= 1'b1;
    end else begin
      reset_seen_reg <= 1'b0;
    end
  end
  // Flight marker has no reset: it must outlive the reset that it reports
  always_ff @(posedge pclk) begin
    if (presetn) live_reg <= (!idle && !op_done) || do_erase || do_program;
  end

  // ----------------------------------------
  // Unlock sequence
  // ----------------------------------------
  // Two keys in order, then the next control write may set the write bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_reg <= pfsw_pkg::PFSW_KEY_NONE;
    end else if (wr_acc && hit_unl) begin
      case (key_reg)
        pfsw_pkg::PFSW_KEY_NONE:
          key_reg <= (pwdata[7:0] == `PFSW_KEY_FIRST) ? pfsw_pkg::PFSW_KEY_HALF
                                                       : pfsw_pkg::PFSW_KEY_NONE;
        pfsw_pkg::PFSW_KEY_HALF:
          key_reg <= (pwdata[7:0] == `PFSW_KEY_SECOND) ? pfsw_pkg::PFSW_KEY_OPEN
                                                        : pfsw_pkg::PFSW_KEY_NONE;
        default:
          key_reg <= pfsw_pkg::PFSW_KEY_NONE;
      endcase
    end else if (wr_acc) begin
      key_reg <= pfsw_pkg::PFSW_KEY_NONE;
    end
  end

  // ----------------------------------------
  // Sequencer and timer
  // ----------------------------------------
  // Self-write only knows row erase and program; no bulk erase path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pfsw_pkg::PFSW_IDLE;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        pfsw_pkg::PFSW_IDLE: begin
          if (do_erase) begin
            state_reg <= pfsw_pkg::PFSW_ERASE;
            timer_reg <= WRITE_CYCLES;
          end else if (do_program) begin
            state_reg <= pfsw_pkg::PFSW_PROGRAM;
            timer_reg <= WRITE_CYCLES;
          end
        end
        default: begin
          timer_reg <= timer_reg - 32'h0000_0001;
          if (op_done) state_reg <= pfsw_pkg::PFSW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Array, latches and protection
  // ----------------------------------------
  // Synchronise external programmer pins before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_reg <= 2'b00;
      sync_b_reg <= 2'b00;
      cp_strap_reg <= 1'b0;
      cp_reg <= 1'b0;
    end else begin
      sync_a_reg <= {ext_prog_mode, ext_bulk_erase};
      sync_b_reg <= sync_a_reg;
      cp_strap_reg <= code_protect_bit;
      if (&sync_b_reg) cp_reg <= 1'b0;
      else cp_reg <= cp_strap_reg | cp_reg;
    end
  end

  wire ext_mode = sync_b_reg[1];
  wire bulk = sync_b_reg[0] && ext_mode;

  // Data ports: fetch and pointer read only; external read blocked by protect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_data <= 14'h0000;
      ptr_data <= 14'h0000;
      ext_rdata <= 14'h0000;
    end else begin
      fetch_data <= flash_mem[fetch_addr];
      ptr_data <= flash_mem[ptr_addr];
      ext_rdata <= (cp_reg && ext_mode) ? 14'h0000 : flash_mem[ext_addr];
    end
  end

  // Latches fill on latch-only writes; program ANDs them in, erase sets the row
  genvar gi;
  generate
    for (gi = 0; gi < ROW_WORDS; gi++) begin : g_row
      always_ff @(posedge pclk) begin
        if (do_latch_only && row_idx == ROW_W'(gi)) begin
          latch_mem[gi] <= wdata_word;
        end else if (do_program && row_idx == ROW_W'(gi)) begin
          latch_mem[gi] <= wdata_word;
        end
        if (bulk) begin
          cfg_mem[gi] <= `PFSW_ERASED_WORD;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) latch_used[gi] <= 1'b0;
        else if ((do_latch_only || do_program) && row_idx == ROW_W'(gi))
          latch_used[gi] <= 1'b1;
        else if (op_done && state_reg == pfsw_pkg::PFSW_PROGRAM) latch_used[gi] <= 1'b0;
      end
    end
  endgenerate

  // Commit at the end of the timed operation; row base from current address
  wire [ADDR_W-1:0] row_base = {word_addr[ADDR_W-1:ROW_W], {ROW_W{1'b0}}};
  always_ff @(posedge pclk) begin
    if (bulk) begin
      for (int i = 0; i < DEPTH; i++) flash_mem[i] <= `PFSW_ERASED_WORD;
    end else if (op_done && state_reg == pfsw_pkg::PFSW_ERASE) begin
      for (int i = 0; i < ROW_WORDS; i++)
        flash_mem[row_base + ADDR_W'(i)] <= `PFSW_ERASED_WORD;
    end else if (op_done && state_reg == pfsw_pkg::PFSW_PROGRAM) begin
      for (int i = 0; i < ROW_WORDS; i++)
        if (latch_used[i])
          flash_mem[row_base + ADDR_W'(i)] <=
            flash_mem[row_base + ADDR_W'(i)] & latch_mem[i];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  no_start_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    (want_write && !pwdata[`PFSW_BIT_ENABLE]) |=> !write_reg)
    else $error("operation started while disabled");
  unlock_needed_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(write_reg) |-> $past(key_reg) == pfsw_pkg::PFSW_KEY_OPEN)
    else $error("write bit set without unlock");
  timed_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> busy[*8])
    else $error("operation shorter than timer");
  write_sticks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && !op_done) |=> write_reg)
    else $error("write bit dropped early");
  erase_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_done && state_reg == pfsw_pkg::PFSW_ERASE) |=> !erase_reg)
    else $error("erase bit not cleared");
  prot_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_prot |=> err_reg && !busy)
    else $error("protected write not flagged");
  latch_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    do_latch_only |=> !busy)
    else $error("latch load started memory write");
  cp_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cp_reg && ext_mode) |=> ext_rdata == 14'h0000)
    else $error("protected data leaked");
endmodule

/* File: bench/test_program_flash_self_write_control.sv */
// Self-checking testbench for the flash self-write sequencer
`timescale 1ns/10ps
`include "pfsw_defines.svh"

module test_program_flash_self_write_control;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  localparam int WC = 16;
  typedef struct {
    string what;
    int kind;
    logic [31:0] exp;
    logic [31:0] mask;
  } pfsw_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, got;
  logic [1:0] write_protect_field;
  logic code_protect_bit, ext_prog_mode, ext_bulk_erase, probe;
  logic [12:0] fetch_addr, ptr_addr, ext_addr, base;
  logic [13:0] fetch_data, ptr_data, ext_rdata, d1, d2;
  int n_errors, checked, k;
  pfsw_note_t notes[$];
  pfsw_note_t n;

`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

  pfsw_top #(.WRITE_CYCLES(WC)) i_pfsw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_protect_field(write_protect_field),
    .code_protect_bit(code_protect_bit), .ext_prog_mode(ext_prog_mode),
    .ext_bulk_erase(ext_bulk_erase), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .ptr_addr(ptr_addr), .ptr_data(ptr_data), .ext_addr(ext_addr), .ext_rdata(ext_rdata),
    .busy(busy));

  // Clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Monitor: pops the oldest note whenever a result shows
  // ----------------------------------------
  // Read data stands through the access phase and is taken at its completing edge
  always @(posedge pclk) begin
    if (((psel && penable && pready && !pwrite) || probe) && notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: got = prdata;
        1: got = {31'h0, pslverr};
        2: got = {18'h0, fetch_data};
        3: got = {18'h0, ptr_data};
        4: got = {18'h0, ext_rdata};
        default: got = {31'h0, busy};
      endcase
      `CHECK(n.what, n.exp & n.mask, got & n.mask)
    end
  end

  // ----------------------------------------
  // Bus and probe tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at an edge
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(string what, int kind, logic [11:0] a, logic [31:0] exp, logic [31:0] m);
    notes.push_back('{what, kind, exp, m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic look(string what, int kind, logic [31:0] exp);
    notes.push_back('{what, kind, exp, 32'hffffffff});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  task automatic load(logic [12:0] a, logic [13:0] d);
    apb(1'b1, `PFSW_ADDR_LOW_OFS, {24'h0, a[7:0]});
    apb(1'b1, `PFSW_ADDR_HIGH_OFS, {27'h0, a[12:8]});
    apb(1'b1, `PFSW_DATA_LOW_OFS, {24'h0, d[7:0]});
    apb(1'b1, `PFSW_DATA_HIGH_OFS, {26'h0, d[13:8]});
  endtask

  // Keys immediately ahead of the control write, nothing in between
  task automatic cmd(logic [7:0] c);
    apb(1'b1, `PFSW_UNLOCK_OFS, {24'h0, `PFSW_KEY_FIRST});
    apb(1'b1, `PFSW_UNLOCK_OFS, {24'h0, `PFSW_KEY_SECOND});
    apb(1'b1, `PFSW_CON1_OFS, {24'h0, c});
  endtask

  task automatic read_word(logic [12:0] a, logic [13:0] d);
    apb(1'b1, `PFSW_ADDR_LOW_OFS, {24'h0, a[7:0]});
    apb(1'b1, `PFSW_ADDR_HIGH_OFS, {27'h0, a[12:8]});
    apb(1'b1, `PFSW_CON1_OFS, 32'h01);
    rd("word low", 0, `PFSW_DATA_LOW_OFS, {24'h0, d[7:0]}, 32'hffffffff);
    rd("word high", 0, `PFSW_DATA_HIGH_OFS, {26'h0, d[13:8]}, 32'hffffffff);
  endtask

  // Bounded wait for the timed operation to finish
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (busy !== 1'b0 && t < 200);
    if (busy !== 1'b0) begin
      n_errors++;
      $display("mismatch busy expected 0 seen %b", busy);
    end
  endtask

  task automatic print_verdict();
    n_errors += notes.size();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the full sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, probe} = '0;
    {paddr, pwdata, n_errors, checked} = '0;
    {code_protect_bit, ext_prog_mode, ext_bulk_erase} = '0;
    {fetch_addr, ptr_addr, ext_addr} = '0;
    write_protect_field = 2'b11;
    presetn = 1'b0;
    void'($urandom(32'h97595a96));
    base = {8'($urandom), 5'h0};
    k = $urandom % 31;
    d1 = 14'($urandom);
    d2 = 14'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl reset", 0, `PFSW_CON1_OFS, 32'h0, 32'hfffffff7);
    rd("unmapped", 1, 12'h018, 32'h1, 32'h1);
    load(base + 13'd5, 14'h0);
    cmd(8'h16);
    look("busy erase", 5, 32'h1);
    apb(1'b1, `PFSW_CON1_OFS, 32'h0);
    look("busy kept", 5, 32'h1);
    wait_idle();
    rd("ctrl done", 0, `PFSW_CON1_OFS, 32'h04, 32'h16);
    read_word(base + 13'd31, `PFSW_ERASED_WORD);
    read_word(base, `PFSW_ERASED_WORD);
    load(base + 13'(k), d1);
    cmd(8'h26);
    look("busy latch", 5, 32'h0);
    load(base + 13'd31, d2);
    cmd(8'h06);
    wait_idle();
    read_word(base + 13'(k), d1);
    read_word(base + 13'd31, d2);
    load(base + 13'(k), d2);
    cmd(8'h06);
    wait_idle();
    read_word(base + 13'(k), d1 & d2);
    fetch_addr <= base + 13'(k);
    ptr_addr <= base + 13'(k);
    ext_addr <= base + 13'(k);
    ext_prog_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    look("fetch", 2, {18'h0, d1 & d2});
    look("pointer", 3, {18'h0, d1 & d2});
    cmd(8'h02);
    look("busy off", 5, 32'h0);
    apb(1'b1, `PFSW_CON1_OFS, 32'h06);
    look("busy nokey", 5, 32'h0);
    rd("error set", 0, `PFSW_CON1_OFS, 32'h08, 32'h0a);
    apb(1'b1, `PFSW_CON1_OFS, 32'h0);
    rd("error clr", 0, `PFSW_CON1_OFS, 32'h0, 32'h0a);
    load(base + 13'(k), 14'h3fff);
    cmd(8'h06);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("error reset", 0, `PFSW_CON1_OFS, 32'h08, 32'hff);
    apb(1'b1, `PFSW_CON1_OFS, 32'h0);
    write_protect_field <= 2'b00;
    load(base + 13'(k), 14'h0);
    cmd(8'h06);
    wait_idle();
    rd("error wp", 0, `PFSW_CON1_OFS, 32'h08, 32'h0a);
    read_word(base + 13'(k), d1 & d2);
    look("ext wp", 4, {18'h0, d1 & d2});
    code_protect_bit <= 1'b1;
    repeat (4) @(posedge pclk);
    look("ext cp", 4, 32'h0);
    read_word(base + 13'(k), d1 & d2);
    code_protect_bit <= 1'b0;
    repeat (4) @(posedge pclk);
    look("ext sticky", 4, 32'h0);
    ext_bulk_erase <= 1'b1;
    repeat (4 * WC + 20) @(posedge pclk);
    ext_bulk_erase <= 1'b0;
    wait_idle();
    look("ext bulk", 4, {18'h0, `PFSW_ERASED_WORD});
    write_protect_field <= 2'b11;
    load(base + 13'(k), d1);
    cmd(8'h06);
    wait_idle();
    apb(1'b1, `PFSW_CON1_OFS, 32'h41);
    rd("cfg low", 0, `PFSW_DATA_LOW_OFS, 32'hff, 32'hff);
    rd("cfg high", 0, `PFSW_DATA_HIGH_OFS, 32'h3f, 32'hff);
    read_word(base + 13'(k), d1);
    repeat (3) @(posedge pclk);
    print_verdict();
  end
endmodule
